/* File: logic/etdt_buf2.v */
// two-entry valid/ready buffer between the read and write halves of a transfer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "etdt_regs.vh"

module etdt_buf2 #(
  parameter W = 32
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // filling side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // draining side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:1];
  reg wptr_reg;
  reg rptr_reg;
  reg [1:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (srst) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        mem_reg[wptr_reg] <= in_data;
        wptr_reg <= ~wptr_reg;
      end
      if (pop)
        rptr_reg <= ~rptr_reg;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule

/* File: logic/etdt_core.v */
// event-triggered transfer controller: selector slots, descriptor fetch, transfer, write-back
// assumes a word-wide memory master port answered by mem_ack and one clock domain
`timescale 1ns/1ns
`include "etdt_regs.vh"

// Notes on behaviour
// RULE1 - an activation runs the transfer held in the descriptor of the activating vector.
// RULE2 - software has the vector table and descriptors in memory before any activation.
// RULE3 - normal mode moves one word per activation and writes back addresses and count.
// RULE4 - repeat mode moves one word per activation and rewinds the repeat side after a full run.
// RULE5 - block mode moves one whole block of the programmed length per activation.
// RULE6 - a slot with its activation enable set starts the controller instead of the cpu.
// RULE7 - the slot index 0 to 31 is the vector number that locates the descriptor.
// RULE8 - each slot has a five-bit source select choosing which peripheral request drives it.
// RULE9 - with chain enable set the next descriptor in memory runs in the same activation. Here, with chain-end also set, it chains only once end_reg is set.
// RULE10 - software clears chain enable only in the last descriptor of a list.
// RULE11 - each finished activation gives a completion pulse for the power controller.
// RULE12 - chained descriptors run in ascending order, write-back first, no new activation meanwhile.
// RULE13 - repeat reloads its count at zero; normal raises its end interrupt when the count hits zero.
module etdt_core #(
  parameter ADR_W = 8,
  parameter NSRC = 32
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // wishbone register slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // peripheral request pulses
  input wire [NSRC-1:0] periph_req,
  // cpu interrupt lines and status
  output reg [31:0] cpu_irq,
  output reg xfer_done,
  output reg busy,
  // system bus master
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack
);
  localparam S_IDLE = 3'h0;
  localparam S_VEC = 3'h1;
  localparam S_DESC = 3'h2;
  localparam S_RD = 3'h3;
  localparam S_WR = 3'h4;
  localparam S_WB = 3'h5;

  // registers
  reg [4:0] src_sel_reg [0:31];
  reg [31:0] act_en_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] base_reg;
  reg [31:0] pend_reg;
  reg [2:0] state_reg;
  reg [4:0] vec_reg;
  reg [1:0] widx_reg;
  reg [31:0] desc_ptr_reg;
  reg [31:0] d_mode_reg;
  reg [31:0] d_src_reg;
  reg [31:0] d_dst_reg;
  reg [31:0] d_cnt_reg;
  reg end_reg;
  reg [31:0] slot_fire;
  reg [31:0] pend_next;
  reg [31:0] irq_next;
  integer k, j;
  function [31:0] f_onehot;
    input [4:0] v;
    begin
      f_onehot = 32'h0000_0001 << v;
    end
  endfunction
  function [31:0] f_wmask;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      f_wmask = old;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          f_wmask[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction
  // step one word up or down (fixed holds), or rewind over n-1 words already stepped
  function [31:0] f_step;
    input [31:0] a;
    input [1:0] am;
    input rew;
    input [7:0] n;
    reg [31:0] span;
    begin
      span = {22'h0, n - 8'h01, 2'h0};
      if (am == `ETDT_AM_INC)
        f_step = rew ? a - span : a + `ETDT_WORD_BYTES;
      else if (am == `ETDT_AM_DEC)
        f_step = rew ? a + span : a - `ETDT_WORD_BYTES;
      else
        f_step = a;
    end
  endfunction
  // descriptor fields
  wire [1:0] d_mode = d_mode_reg[`ETDT_MODE_LSB +: 2];
  wire rep_dst = d_mode_reg[`ETDT_REP_DST_BIT];
  wire [1:0] d_sam = d_mode_reg[`ETDT_SAM_LSB +: 2];
  wire [1:0] d_dam = d_mode_reg[`ETDT_DAM_LSB +: 2];
  wire d_chain = d_mode_reg[`ETDT_CHAIN_BIT];
  wire d_chain_end = d_mode_reg[`ETDT_CHAIN_END_BIT];
  wire d_irq_each = d_mode_reg[`ETDT_IRQ_EACH_BIT];
  wire [7:0] d_rem = d_cnt_reg[`ETDT_REM_LSB +: 8];
  wire [7:0] d_rld = d_cnt_reg[`ETDT_RLD_LSB +: 8];
  wire [15:0] d_cnt = d_cnt_reg[`ETDT_CNT_LSB +: 16];
  // arbitration, buffer hookup
  wire pick_any;
  wire [4:0] pick_idx;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [31:0] buf_out_data;
  wire buf_push = (state_reg == S_RD) & mem_req & mem_ack;
  wire buf_pop = (state_reg == S_WR) & ~mem_req & buf_out_valid;
  etdt_prio #(.N(32), .IW(5)) u_prio (
    .req(pend_reg),
    .any(pick_any),
    .idx(pick_idx)
  );
  // read data parks here so a stalled write side loses nothing
  etdt_buf2 #(.W(32)) u_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(mem_rdata),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // per-transfer update
  wire rep_like = (d_mode != `ETDT_MODE_NORMAL);
  wire wrap = rep_like & (d_rem == 8'h01);
  wire [31:0] src_new = f_step(d_src_reg, d_sam, wrap & ~rep_dst, d_rld); // see RULE4
  wire [31:0] dst_new = f_step(d_dst_reg, d_dam, wrap & rep_dst, d_rld); // see RULE4
  wire [7:0] rem_new = wrap ? d_rld : d_rem - 8'h01; // see RULE13
  wire cnt_dec = (d_mode == `ETDT_MODE_NORMAL) | ((d_mode == `ETDT_MODE_BLOCK) & wrap);
  wire [15:0] cnt_new = cnt_dec ? d_cnt - 16'h0001 : d_cnt; // see RULE3
  wire at_end = (d_mode == `ETDT_MODE_REPEAT) ? wrap : (cnt_dec & (d_cnt == 16'h0001));
  wire blk_more = (d_mode == `ETDT_MODE_BLOCK) & ~wrap; // see RULE5
  wire wb_last = (state_reg == S_WB) & mem_req & mem_ack & (widx_reg == `ETDT_W_CNT);
  wire go_chain = d_chain & (~d_chain_end | end_reg); // see RULE9
  wire fin_irq = wb_last & (d_irq_each | end_reg); // see RULE13

  // slot firing and pending activations
  always @* begin
    for (k = 0; k < 32; k = k + 1)
      slot_fire[k] = periph_req[src_sel_reg[k]]; // see RULE8
    pend_next = pend_reg;
    if ((state_reg == S_IDLE) & pick_any & ctrl_reg[`ETDT_CTRL_EN_BIT])
      pend_next = pend_next & ~f_onehot(pick_idx);
    pend_next = pend_next | (slot_fire & act_en_reg); // set wins over clear, see RULE6
    irq_next = slot_fire & ~act_en_reg; // see RULE6
    if (fin_irq)
      irq_next = irq_next | f_onehot(vec_reg);
  end

  // register slave: one wait cycle, unmapped reads zero, unmapped writes dropped
  wire wb_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [31:0] wb_adr_ext = {{(32 - ADR_W){1'b0}}, wb_adr_i};
  wire [7:0] wb_off = {wb_adr_ext[7:2], 2'h0};
  wire slot_hit = ~wb_off[`ETDT_OFF_SLOT_HI_BIT];
  wire [4:0] slot_idx = wb_off[6:2];

  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      act_en_reg <= 32'h0000_0000;
      ctrl_reg <= `ETDT_CTRL_RST;
      base_reg <= `ETDT_BASE_RST;
      for (j = 0; j < 32; j = j + 1)
        src_sel_reg[j] <= 5'h00;
    end else begin
      wb_ack_o <= wb_go;
      wb_dat_o <= 32'h0000_0000;
      if (wb_go & slot_hit) begin
        wb_dat_o <= {23'h0, act_en_reg[slot_idx], 3'h0, src_sel_reg[slot_idx]};
        if (wb_we_i & wb_sel_i[0])
          src_sel_reg[slot_idx] <= wb_dat_i[`ETDT_SLOT_SRC_MSB:0]; // see RULE8
        if (wb_we_i & wb_sel_i[1])
          act_en_reg[slot_idx] <= wb_dat_i[`ETDT_SLOT_EN_BIT]; // see RULE6
      end else if (wb_go) begin
        case (wb_off)
          `ETDT_OFF_CTRL: begin
            wb_dat_o <= ctrl_reg;
            if (wb_we_i)
              ctrl_reg <= f_wmask(ctrl_reg, wb_dat_i, wb_sel_i);
          end
          `ETDT_OFF_BASE: begin
            wb_dat_o <= base_reg;
            if (wb_we_i)
              base_reg <= f_wmask(base_reg, wb_dat_i, wb_sel_i);
          end
          `ETDT_OFF_STAT: wb_dat_o <= {19'h0, vec_reg, 5'h0, state_reg};
          `ETDT_OFF_PEND: wb_dat_o <= pend_reg;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // transfer engine
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      pend_reg <= 32'h0000_0000;
      vec_reg <= 5'h00;
      widx_reg <= 2'h0;
      desc_ptr_reg <= 32'h0000_0000;
      d_mode_reg <= 32'h0000_0000;
      d_src_reg <= 32'h0000_0000;
      d_dst_reg <= 32'h0000_0000;
      d_cnt_reg <= 32'h0000_0000;
      end_reg <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      cpu_irq <= 32'h0000_0000;
      xfer_done <= 1'b0;
      busy <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      cpu_irq <= irq_next;
      xfer_done <= 1'b0;
      busy <= (state_reg != S_IDLE);
      case (state_reg)
        S_IDLE: begin
          // only here is a new activation taken, so a chain never interleaves, see RULE12
          if (pick_any & ctrl_reg[`ETDT_CTRL_EN_BIT]) begin
            vec_reg <= pick_idx;
            mem_addr <= base_reg + {25'h0, pick_idx, 2'h0}; // see RULE7
            mem_we <= 1'b0;
            mem_req <= 1'b1;
            state_reg <= S_VEC;
          end
        end
        S_VEC: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            desc_ptr_reg <= mem_rdata; // see RULE1
            widx_reg <= `ETDT_W_MODE;
            state_reg <= S_DESC;
          end
        end
        S_DESC: begin
          if (~mem_req) begin
            mem_addr <= desc_ptr_reg + {28'h0, widx_reg, 2'h0};
            mem_we <= 1'b0;
            mem_req <= 1'b1;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            case (widx_reg)
              `ETDT_W_MODE: d_mode_reg <= mem_rdata;
              `ETDT_W_SRC: d_src_reg <= mem_rdata;
              `ETDT_W_DST: d_dst_reg <= mem_rdata;
              default: d_cnt_reg <= mem_rdata;
            endcase
            widx_reg <= widx_reg + 2'h1;
            if (widx_reg == `ETDT_W_CNT)
              state_reg <= S_RD;
          end
        end
        S_RD: begin
          // back-pressure: no read goes out while the buffer is full
          if (~mem_req & buf_in_ready) begin
            mem_addr <= d_src_reg;
            mem_we <= 1'b0;
            mem_req <= 1'b1;
          end else if (mem_req & mem_ack) begin
            mem_req <= 1'b0;
            state_reg <= S_WR;
          end
        end
        S_WR: begin
          if (buf_pop) begin
            mem_addr <= d_dst_reg;
            mem_wdata <= buf_out_data;
            mem_we <= 1'b1;
            mem_req <= 1'b1;
          end else if (mem_req & mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            d_src_reg <= src_new;
            d_dst_reg <= dst_new;
            if (rep_like)
              d_cnt_reg[`ETDT_REM_LSB +: 8] <= rem_new;
            d_cnt_reg[`ETDT_CNT_LSB +: 16] <= cnt_new; // see RULE3
            end_reg <= at_end;
            widx_reg <= `ETDT_W_SRC;
            state_reg <= blk_more ? S_RD : S_WB; // see RULE5
          end
        end
        S_WB: begin
          // write back before the next descriptor is touched, see RULE12
          if (~mem_req) begin
            mem_addr <= desc_ptr_reg + {28'h0, widx_reg, 2'h0};
            mem_wdata <= (widx_reg == `ETDT_W_SRC) ? d_src_reg :
                         (widx_reg == `ETDT_W_DST) ? d_dst_reg : d_cnt_reg;
            mem_we <= 1'b1;
            mem_req <= 1'b1;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            widx_reg <= widx_reg + 2'h1;
            if (wb_last) begin
              if (go_chain) begin
                desc_ptr_reg <= desc_ptr_reg + `ETDT_DESC_BYTES; // see RULE9
                widx_reg <= `ETDT_W_MODE;
                state_reg <= S_DESC;
              end else begin
                xfer_done <= 1'b1; // see RULE11
                state_reg <= S_IDLE;
              end
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: logic/etdt_prio.v */
// fixed-priority pick of the lowest pending vector
// purely combinational; the caller registers whatever it keeps
`timescale 1ns/1ns

module etdt_prio #(
  parameter N = 32,
  parameter IW = 5
) (
  // pending vectors
  input wire [N-1:0] req,
  // chosen vector
  output reg any,
  output reg [IW-1:0] idx
);
  integer i;
  always @* begin
    any = 1'b0;
    idx = {IW{1'b0}};
    // lowest index wins; scan from the top so the last hit is the lowest
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule

/* File: pkg/etdt_regs.vh */
// register offsets, field positions and descriptor layout of the event-triggered transfer unit
// included by every design file except the priority picker; definitions only
`ifndef ETDT_REGS_VH
`define ETDT_REGS_VH

// register bus map (byte offsets)
`define ETDT_OFF_SLOT_HI_BIT 7
`define ETDT_OFF_CTRL 8'h80
`define ETDT_OFF_BASE 8'h84
`define ETDT_OFF_STAT 8'h88
`define ETDT_OFF_PEND 8'h8C

// selector slot fields, control enable bit and reset values
`define ETDT_SLOT_SRC_MSB 4
`define ETDT_SLOT_EN_BIT 8
`define ETDT_CTRL_EN_BIT 0
`define ETDT_CTRL_RST 32'h0000_0000
`define ETDT_BASE_RST 32'h0000_0000

// descriptor word indices
`define ETDT_W_MODE 2'h0
`define ETDT_W_SRC 2'h1
`define ETDT_W_DST 2'h2
`define ETDT_W_CNT 2'h3

// descriptor_mode_word_b fields
`define ETDT_MODE_LSB 0
`define ETDT_MODE_NORMAL 2'h0
`define ETDT_MODE_REPEAT 2'h1
`define ETDT_MODE_BLOCK 2'h2
`define ETDT_REP_DST_BIT 2
`define ETDT_SAM_LSB 3
`define ETDT_DAM_LSB 5
`define ETDT_CHAIN_BIT 7
`define ETDT_CHAIN_END_BIT 8
`define ETDT_IRQ_EACH_BIT 9
`define ETDT_AM_FIXED 2'h0
`define ETDT_AM_INC 2'h1
`define ETDT_AM_DEC 2'h2

// count word fields
`define ETDT_REM_LSB 0
`define ETDT_RLD_LSB 8
`define ETDT_CNT_LSB 16

// strides
`define ETDT_WORD_BYTES 32'h0000_0004
`define ETDT_DESC_BYTES 32'h0000_0010

`endif

/* File: tb/etdt_core_sva.sv */
// port assertions for the event-triggered transfer engine
// assumes it is bound onto etdt_core; one clock, srst synchronous active high
`timescale 1ns/1ns
module etdt_core_sva #(
  parameter ADR_W = 8,
  parameter NSRC = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events and status
  input wire logic [NSRC-1:0] periph_req,
  input wire logic [31:0] cpu_irq,
  input wire logic xfer_done,
  input wire logic busy,
  // memory master
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not acknowledged in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_req_gap: assert property (mem_ack |=> !mem_req)
    else $error("memory request not dropped after ack");
  a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("memory address not word aligned");
  a_done_busy: assert property (xfer_done |-> $past(busy, 2))
    else $error("completion pulse without a run");
  a_quiet_release: assert property ($fell(srst) |-> !wb_ack_o && !mem_req
    && !xfer_done && !busy && cpu_irq == 32'h0000_0000)
    else $error("outputs active right after reset");

  c_read_ack: cover property (wb_ack_o && !wb_we_i);
  c_mem_write: cover property (mem_ack && mem_we);
  c_done: cover property (xfer_done);
endmodule

bind etdt_core etdt_core_sva #(.ADR_W(ADR_W), .NSRC(NSRC)) u_sva (.clk, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .periph_req,
  .cpu_irq, .xfer_done, .busy, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

/* File: tb/etdt_sram_model.sv */
// sram model answering the engine's word accesses, at once or stalled
// assumes the bench preloads and inspects m by hierarchy
`timescale 1ns/1ns
module etdt_sram_model (
  // clock, reset, stall
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] m [0:255];
  logic [1:0] w;

  // read data is not held after ack: it toggles so a late sample shows
  always @(posedge clk) begin
    mem_rdata <= ~mem_rdata;
    if (srst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      w <= 2'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      w <= 2'h0;
    end else if (mem_req && (!slow || w == 2'h3)) begin
      mem_ack <= 1'b1;
      if (mem_we)
        m[mem_addr[9:2]] <= mem_wdata;
      else
        mem_rdata <= m[mem_addr[9:2]];
    end else if (mem_req) begin
      w <= w + 2'h1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// bench: register access, pass-through, normal, block, repeat and chained runs
// assumes etdt_core with its checker and etdt_sram_model compiled before it
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] periph_req = 32'h0;
  logic slow = 1'b0;
  wire [31:0] wb_dat_o, cpu_irq, mem_addr, mem_wdata, mem_rdata;
  wire wb_ack_o, xfer_done, busy, mem_req, mem_we, mem_ack;
  logic [31:0] irq_seen = 32'h0;
  logic [31:0] rd;
  int done_cnt = 0;
  int num_errors = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  etdt_core dut (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .periph_req, .cpu_irq, .xfer_done, .busy, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  etdt_sram_model mem (.clk, .srst, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);

  // pulses last one cycle, so gather them here
  always @(posedge clk) begin
    if (srst)
      irq_seen <= 32'h0;
    else
      irq_seen <= irq_seen | cpu_irq;
    if (xfer_done === 1'b1)
      done_cnt <= done_cnt + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int t = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    chk("wb ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(a, 1'b0, 32'h0, 4'hF);
    chk(what, exp, rd);
  endtask

  task automatic put(input int a, input logic [31:0] v);
    mem.m[a[9:2]] = v;
  endtask

  task automatic mchk(input int a, input logic [31:0] exp, input string what);
    chk(what, exp, mem.m[a[9:2]]);
  endtask

  task automatic pulse(input int s);
    @(posedge clk);
    periph_req[s] <= 1'b1;
    @(posedge clk);
    periph_req <= 32'h0;
  endtask

  task automatic wait_done(input int n);
    int t = 0;
    while (done_cnt < n && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk("activations", 32'(n), 32'(done_cnt));
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    complete_run();
  end

  initial begin
    put(32'h10C, 32'h0000_0200);
    put(32'h110, 32'h0000_0240);
    put(32'h200, 32'h0000_01AA);
    put(32'h204, 32'h0000_0300);
    put(32'h208, 32'h0000_0320);
    put(32'h20C, 32'h0001_0202);
    put(32'h210, 32'h0000_0025);
    put(32'h214, 32'h0000_0308);
    put(32'h218, 32'h0000_0330);
    put(32'h21C, 32'h0000_0201);
    put(32'h240, 32'h0000_0028);
    put(32'h244, 32'h0000_0340);
    put(32'h248, 32'h0000_0360);
    put(32'h24C, 32'h0002_0000);
    put(32'h300, 32'h1111_1111);
    put(32'h304, 32'h2222_2222);
    put(32'h308, 32'h3333_3333);
    put(32'h340, 32'hA5A5_0001);
    put(32'h344, 32'hA5A5_0002);
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdc(8'h80, 32'h0, "ctrl reset");
    rdc(8'h84, 32'h0, "base reset");
    rdc(8'h0C, 32'h0, "slot reset");
    wb(8'h90, 1'b1, 32'hFFFF_FFFF, 4'hF);
    rdc(8'h90, 32'h0, "unmapped");
    wb(8'h0C, 1'b1, 32'h0000_0105, 4'hF);
    wb(8'h10, 1'b1, 32'h0000_0106, 4'hF);
    wb(8'h08, 1'b1, 32'h0000_0107, 4'h1);
    wb(8'h84, 1'b1, 32'h0000_0100, 4'hF);
    rdc(8'h08, 32'h0000_0007, "slot lane0");
    rdc(8'h0C, 32'h0000_0105, "slot word");
    pulse(7);
    repeat (3) @(posedge clk);
    chk("pass irq", 32'h4, irq_seen);
    pulse(6);
    repeat (3) @(posedge clk);
    rdc(8'h8C, 32'h0000_0010, "pending");
    wb(8'h80, 1'b1, 32'h0000_0001, 4'hF);
    wait_done(1);
    mchk(32'h360, 32'hA5A5_0001, "normal dst");
    mchk(32'h244, 32'h0000_0344, "normal src wb");
    mchk(32'h248, 32'h0000_0364, "normal dst wb");
    mchk(32'h24C, 32'h0001_0000, "normal cnt wb");
    chk("no early end", 32'h0, irq_seen & 32'h10);
    slow <= 1'b1;
    pulse(5);
    repeat (10) @(posedge clk);
    chk("busy run", 32'h1, {31'h0, busy});
    pulse(6);
    wait_done(3);
    slow <= 1'b0;
    mchk(32'h320, 32'h1111_1111, "block w0");
    mchk(32'h324, 32'h2222_2222, "block w1");
    mchk(32'h204, 32'h0000_0300, "block src wb");
    mchk(32'h208, 32'h0000_0328, "block dst wb");
    mchk(32'h330, 32'h3333_3333, "chained word");
    mchk(32'h218, 32'h0000_032C, "repeat rewind");
    mchk(32'h21C, 32'h0000_0202, "repeat reload");
    mchk(32'h364, 32'hA5A5_0002, "normal second");
    mchk(32'h24C, 32'h0000_0000, "normal count end");
    chk("irq set", 32'h1C, irq_seen);
    rdc(8'h8C, 32'h0, "pending clear");
    chk("busy idle", 32'h0, {31'h0, busy});
    complete_run();
  end
endmodule
